/* File: include/spi_switch_pkg.sv */
// Purpose: shared constants and types for the switch serial port
// Assumes: sys_clk at 20 MHz
// Notes: register addresses are 7-bit frame addresses
package spi_switch_pkg;
  localparam longint SYS_CLK_HZ = 20_000_000;
  localparam longint INIT_WAIT_US = 120;
  localparam logic [11:0] INIT_COUNT =
    12'((INIT_WAIT_US * SYS_CLK_HZ + 64'd999_999) / 64'd1_000_000);

  localparam logic [6:0] ADDR_SWITCH = 7'h01;
  localparam logic [6:0] ADDR_CONFIG = 7'h02;
  localparam logic [6:0] ADDR_FLAGS = 7'h03;
  localparam logic [6:0] ADDR_BURST = 7'h05;
  localparam logic [6:0] ADDR_RESET_KEY = 7'h0b;

  localparam logic [7:0] SWITCH_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h06;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] BURST_RESET = 8'h00;
  localparam logic [7:0] KEY_RESET = 8'h00;
  localparam logic [7:0] CONFIG_MASK = 8'h07;
  localparam logic [7:0] BURST_MASK = 8'h01;

  localparam int CFG_CRC_BIT = 0;
  localparam int CFG_SCLK_BIT = 1;
  localparam int CFG_RW_BIT = 2;
  localparam int FLAG_CRC_BIT = 0;
  localparam int FLAG_SCLK_BIT = 1;
  localparam int FLAG_RW_BIT = 2;
  localparam int BURST_BIT = 0;

  localparam logic [15:0] CLEAR_FRAME = 16'h6ca9;
  localparam logic [7:0] ALIGN_BYTE = 8'h25;
  localparam logic [7:0] KEY_FIRST = 8'ha3;
  localparam logic [7:0] KEY_SECOND = 8'h05;
  localparam logic [7:0] CRC_POLY = 8'h07;

  localparam logic [4:0] FRAME_BITS = 5'd16;
  localparam logic [4:0] CRC_FRAME_BITS = 5'd24;
  localparam logic [4:0] ADDR_BITS_DONE = 5'd8;

  localparam logic [4:0] HALF_CYCLES = 5'd10;
  localparam logic [1:0] HOST_FRAME = 2'h0;
  localparam logic [1:0] HOST_STATUS = 2'h1;
  localparam logic [1:0] HOST_RESPONSE = 2'h2;
  localparam logic [1:0] HOST_RX_CRC = 2'h3;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_SETUP = 2'b01,
    HS_SHIFT = 2'b11,
    HS_GAP = 2'b10
  } host_state_e;
endpackage : spi_switch_pkg

/* File: include/spi_switch_if.sv */
// Purpose: serial link between controller and switch device
// Assumes: both ends on the same system clock domain family
// Notes: all four lines are driven push-pull
`timescale 1ns/1ns
interface spi_switch_if;
  logic sclk;
  logic csB;
  logic sdi;
  logic sdo;
  modport ctrl (output sclk, output csB, output sdi, input sdo);
  modport dev (input sclk, input csB, input sdi, output sdo);
endinterface : spi_switch_if

/* File: src/crc8_calc.sv */
// Purpose: eight-bit checksum of a 16-bit frame payload
// Assumes: zero seed, msb first
// Notes: purely combinational
`timescale 1ns/1ns
module crc8_calc
  import spi_switch_pkg::*;
(
  // payload in, checksum out
  input wire logic [15:0] payload,
  output logic [7:0] crc
);
  always_comb begin
    logic fb;
    fb = 1'b0;
    crc = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      fb = crc[7] ^ payload[i];
      crc = {crc[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    end
  end
endmodule : crc8_calc

/* File: src/switch_device.sv */
// Purpose: register bank of the eight-switch device behind its serial port
// Assumes: link pins sampled by sys_clk through two flip-flops
// Notes: frames ignored while the initialization phase runs
//
// Strobed register access was decided locally.
`timescale 1ns/1ns
module switch_device
  import spi_switch_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // serial link
  spi_switch_if.dev link,
  // user side
  output logic [7:0] switchClose,
  output logic [7:0] errorFlags,
  output logic initBusy
);
  logic [2:0] pinMeta_ff;
  logic [2:0] pinSync_ff;
  logic [2:0] pinPrev_ff;
  logic [11:0] initCnt_ff;
  logic [11:0] nxt_initCnt;
  logic initBusy_ff;
  logic frameOn_ff;
  logic [23:0] rxShift_ff;
  logic [4:0] rxPos_ff;
  logic [1:0] cmds_ff;
  logic [7:0] rdByte_ff;
  logic [7:0] txHead_ff;
  logic [4:0] txPos_ff;
  logic [7:0] outShift_ff;
  logic [7:0] switch_ff;
  logic [7:0] cfg_ff;
  logic [7:0] flags_ff;
  logic [7:0] burst_ff;
  logic [7:0] key_ff;
  logic keyArmed_ff;

  logic sclkS, csBS, sdiS;
  logic sclkRise, sclkFall, csFall, csRise;
  logic crcEn, sclkEn, rwEn, burstEn;
  logic [4:0] frameLen, nxtRxPos, nxtTxPos;
  logic rise, fall, exec, csEnd;
  logic [23:0] full;
  logic [15:0] payload;
  logic [7:0] calcCrc, txCrc;
  logic [6:0] addr, headAddr;
  logic isRead, isClear, crcOk, rdValid, wrValid;
  logic doWrite, clearNow, softReset;
  logic [7:0] setBits;

  // two-flop synchronisers for sclk, csB, sdi
  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        // idle levels, so no false edge follows reset
        pinMeta_ff[i] <= (i == 1);
        pinSync_ff[i] <= (i == 1);
        pinPrev_ff[i] <= (i == 1);
      end else begin
        pinMeta_ff[i] <= (i == 0) ? link.sclk :
                         (i == 1) ? link.csB : link.sdi;
        pinSync_ff[i] <= pinMeta_ff[i];
        pinPrev_ff[i] <= pinSync_ff[i];
      end
    end
  end

  assign sclkS = pinSync_ff[0];
  assign csBS = pinSync_ff[1];
  assign sdiS = pinSync_ff[2];
  assign sclkRise = sclkS & ~pinPrev_ff[0];
  assign sclkFall = ~sclkS & pinPrev_ff[0];
  assign csFall = ~csBS & pinPrev_ff[1];
  assign csRise = csBS & ~pinPrev_ff[1];

  assign crcEn = cfg_ff[CFG_CRC_BIT];
  assign sclkEn = cfg_ff[CFG_SCLK_BIT];
  assign rwEn = cfg_ff[CFG_RW_BIT];
  assign burstEn = burst_ff[BURST_BIT];
  assign frameLen = crcEn ? CRC_FRAME_BITS : FRAME_BITS;

  // initialization phase
  always_comb begin
    nxt_initCnt = initCnt_ff;
    if (softReset) begin
      nxt_initCnt = INIT_COUNT;
    end else if (initCnt_ff != 12'h000) begin
      nxt_initCnt = initCnt_ff - 12'h001;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      initCnt_ff <= INIT_COUNT;
      initBusy_ff <= 1'b1;
    end else begin
      initCnt_ff <= nxt_initCnt;
      initBusy_ff <= nxt_initCnt != 12'h000;
    end
  end

  // frame bracket by chip select
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      frameOn_ff <= 1'b0;
    end else if (softReset || csRise) begin
      frameOn_ff <= 1'b0;
    end else if (csFall && !initBusy_ff) begin
      frameOn_ff <= 1'b1;
    end
  end

  assign rise = frameOn_ff & sclkRise & ~csBS;
  assign fall = frameOn_ff & sclkFall & ~csBS;
  assign csEnd = frameOn_ff & csRise;
  assign nxtRxPos = rxPos_ff + 5'd1;

  // command executes on its last edge; extra commands need burst
  assign exec = rise && (nxtRxPos == frameLen) &&
                (burstEn || cmds_ff == 2'd0);
  assign full = {rxShift_ff[22:0], sdiS};
  assign payload = crcEn ? full[23:8] : full[15:0];
  assign isRead = payload[15];
  assign addr = payload[14:8];
  assign isClear = payload == CLEAR_FRAME;
  assign crcOk = !crcEn || (calcCrc == full[7:0]);
  assign headAddr = {rxShift_ff[5:0], sdiS};

  crc8_calc u_rx_crc (
    .payload(payload),
    .crc(calcCrc)
  );

  crc8_calc u_tx_crc (
    .payload({txHead_ff, rdByte_ff}),
    .crc(txCrc)
  );

  always_comb begin
    rdValid = (addr == ADDR_SWITCH) || (addr == ADDR_CONFIG) ||
              (addr == ADDR_FLAGS) || (addr == ADDR_BURST) ||
              (addr == ADDR_RESET_KEY);
    wrValid = rdValid && (addr != ADDR_FLAGS);
  end

  // decode of a finished command
  always_comb begin
    doWrite = 1'b0;
    clearNow = 1'b0;
    setBits = 8'h00;
    if (exec) begin
      if (isRead) begin
        setBits[FLAG_RW_BIT] = rwEn && !rdValid;
      end else if (!crcOk) begin
        setBits[FLAG_CRC_BIT] = 1'b1;
      end else if (isClear) begin
        clearNow = 1'b1;
      end else if (!wrValid) begin
        setBits[FLAG_RW_BIT] = rwEn;
      end else begin
        doWrite = 1'b1;
      end
    end
    if (csEnd && sclkEn) begin
      setBits[FLAG_SCLK_BIT] = (rxPos_ff != 5'd0) ||
        (burstEn ? cmds_ff == 2'd0 : cmds_ff != 2'd1);
    end
  end

  assign softReset = doWrite && addr == ADDR_RESET_KEY &&
                     payload[7:0] == KEY_SECOND && keyArmed_ff;

  // receive shifter and clock counting
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rxShift_ff <= 24'h000000;
      rxPos_ff <= 5'd0;
      cmds_ff <= 2'd0;
    end else if (softReset || (csFall && !initBusy_ff)) begin
      rxPos_ff <= 5'd0;
      cmds_ff <= 2'd0;
    end else if (rise) begin
      rxShift_ff <= full;
      if (nxtRxPos == frameLen) begin
        rxPos_ff <= 5'd0;
        if (cmds_ff != 2'd3) begin
          cmds_ff <= cmds_ff + 2'd1;
        end
      end else begin
        rxPos_ff <= nxtRxPos;
      end
    end
  end

  // read target latched once the address is in
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdByte_ff <= 8'h00;
      txHead_ff <= 8'h00;
    end else if (rise && nxtRxPos == ADDR_BITS_DONE) begin
      txHead_ff <= {rxShift_ff[6:0], sdiS};
      case (headAddr)
        ADDR_SWITCH: rdByte_ff <= switch_ff;
        ADDR_CONFIG: rdByte_ff <= cfg_ff;
        ADDR_FLAGS: rdByte_ff <= flags_ff;
        ADDR_BURST: rdByte_ff <= burst_ff;
        ADDR_RESET_KEY: rdByte_ff <= key_ff;
        default: rdByte_ff <= 8'h00;
      endcase
    end
  end

  // transmit: alignment, register data, then checksum
  assign nxtTxPos = txPos_ff + 5'd1;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      txPos_ff <= 5'd0;
      outShift_ff <= 8'h00;
    end else if (csFall && !initBusy_ff) begin
      txPos_ff <= 5'd0;
      outShift_ff <= ALIGN_BYTE;
    end else if (fall) begin
      if (nxtTxPos == frameLen) begin
        txPos_ff <= 5'd0;
        outShift_ff <= ALIGN_BYTE;
      end else begin
        txPos_ff <= nxtTxPos;
        if (nxtTxPos == ADDR_BITS_DONE) begin
          outShift_ff <= rdByte_ff;
        end else if (nxtTxPos == FRAME_BITS) begin
          outShift_ff <= txCrc;
        end else begin
          outShift_ff <= {outShift_ff[6:0], 1'b0};
        end
      end
    end
  end

  // writable registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      switch_ff <= SWITCH_RESET;
      cfg_ff <= CONFIG_RESET;
      burst_ff <= BURST_RESET;
      key_ff <= KEY_RESET;
    end else if (softReset) begin
      switch_ff <= SWITCH_RESET;
      cfg_ff <= CONFIG_RESET;
      burst_ff <= BURST_RESET;
      key_ff <= KEY_RESET;
    end else if (doWrite) begin
      case (addr)
        ADDR_SWITCH: switch_ff <= payload[7:0];
        ADDR_CONFIG: cfg_ff <= payload[7:0] & CONFIG_MASK;
        ADDR_BURST: burst_ff <= payload[7:0] & BURST_MASK;
        ADDR_RESET_KEY: key_ff <= payload[7:0];
        default: key_ff <= key_ff;
      endcase
    end
  end

  // first half of the reset key
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      keyArmed_ff <= 1'b0;
    end else if (softReset) begin
      keyArmed_ff <= 1'b0;
    end else if (exec) begin
      keyArmed_ff <= doWrite && addr == ADDR_RESET_KEY &&
                     payload[7:0] == KEY_FIRST;
    end
  end

  // error flags, a new event wins over a clear
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_ff <= FLAGS_RESET;
    end else if (softReset) begin
      flags_ff <= FLAGS_RESET;
    end else begin
      flags_ff <= ((clearNow ? 8'h00 : flags_ff) | setBits) &
                  CONFIG_MASK;
    end
  end

  assign link.sdo = outShift_ff[7];
  assign switchClose = switch_ff;
  assign errorFlags = flags_ff;
  assign initBusy = initBusy_ff;
endmodule : switch_device

/* File: src/switch_host.sv */
// Purpose: serial controller that sends one command per frame
// Assumes: software drives the plain register port
// Notes: link clock is sys_clk divided by twice HALF_CYCLES
`timescale 1ns/1ns
module switch_host
  import spi_switch_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // serial link
  spi_switch_if.ctrl link,
  // register port
  input wire logic [1:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata
);
  host_state_e state_ff;
  logic sdoMeta_ff, sdoSync_ff;
  logic [11:0] initCnt_ff;
  logic [4:0] halfCnt_ff, bitCnt_ff, frameLen_ff;
  logic [23:0] txShift_ff, rxShift_ff;
  logic [15:0] lastCmd_ff, regRdata_ff;
  logic sclk_ff, csB_ff, sdi_ff, crcMode_ff, keyArmed_ff;
  logic tick, start, finish, softSent;
  logic [15:0] word;
  logic [7:0] wordCrc;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sdoMeta_ff <= 1'b0;
      sdoSync_ff <= 1'b0;
    end else begin
      sdoMeta_ff <= link.sdo;
      sdoSync_ff <= sdoMeta_ff;
    end
  end

  // reserved bits forced to zero
  always_comb begin
    word = regWdata;
    if (!regWdata[15] && regWdata[14:8] == ADDR_CONFIG) begin
      word[7:0] = regWdata[7:0] & CONFIG_MASK;
    end else if (!regWdata[15] && regWdata[14:8] == ADDR_BURST) begin
      word[7:0] = regWdata[7:0] & BURST_MASK;
    end
  end

  crc8_calc u_crc (
    .payload(word),
    .crc(wordCrc)
  );

  assign tick = halfCnt_ff == HALF_CYCLES - 5'd1;
  assign start = regWr && regAddr == HOST_FRAME &&
                 state_ff == HS_IDLE && initCnt_ff == 12'h000;
  assign finish = state_ff == HS_GAP && tick && csB_ff;
  assign softSent = finish && !lastCmd_ff[15] &&
                    lastCmd_ff[14:8] == ADDR_RESET_KEY &&
                    lastCmd_ff[7:0] == KEY_SECOND && keyArmed_ff;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      initCnt_ff <= INIT_COUNT;
    end else if (softSent) begin
      initCnt_ff <= INIT_COUNT;
    end else if (initCnt_ff != 12'h000) begin
      initCnt_ff <= initCnt_ff - 12'h001;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      halfCnt_ff <= 5'd0;
    end else if (state_ff == HS_IDLE || tick) begin
      halfCnt_ff <= 5'd0;
    end else begin
      halfCnt_ff <= halfCnt_ff + 5'd1;
    end
  end

  // frame sequencer, mode 0
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= HS_IDLE;
      sclk_ff <= 1'b0;
      csB_ff <= 1'b1;
      sdi_ff <= 1'b0;
      bitCnt_ff <= 5'd0;
      frameLen_ff <= FRAME_BITS;
      txShift_ff <= 24'h000000;
      rxShift_ff <= 24'h000000;
      lastCmd_ff <= 16'h0000;
    end else begin
      case (state_ff)
        HS_IDLE: begin
          if (start) begin
            state_ff <= HS_SETUP;
            csB_ff <= 1'b0;
            sdi_ff <= word[15];
            bitCnt_ff <= 5'd0;
            lastCmd_ff <= word;
            txShift_ff <= {word, crcMode_ff ? wordCrc : 8'h00};
            frameLen_ff <= crcMode_ff ? CRC_FRAME_BITS
                                      : FRAME_BITS;
          end
        end
        HS_SETUP, HS_SHIFT: begin
          if (tick && !sclk_ff) begin
            state_ff <= HS_SHIFT;
            sclk_ff <= 1'b1;
            rxShift_ff <= {rxShift_ff[22:0], sdoSync_ff};
            txShift_ff <= {txShift_ff[22:0], 1'b0};
            bitCnt_ff <= bitCnt_ff + 5'd1;
          end else if (tick) begin
            sclk_ff <= 1'b0;
            sdi_ff <= txShift_ff[23];
            if (bitCnt_ff == frameLen_ff) begin
              state_ff <= HS_GAP;
            end
          end
        end
        HS_GAP: begin
          if (tick && !csB_ff) begin
            csB_ff <= 1'b1;
          end else if (tick) begin
            state_ff <= HS_IDLE;
          end
        end
        default: state_ff <= HS_IDLE;
      endcase
    end
  end

  // track device crc mode and reset key from sent commands
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      crcMode_ff <= 1'b0;
      keyArmed_ff <= 1'b0;
    end else if (softSent) begin
      crcMode_ff <= 1'b0;
      keyArmed_ff <= 1'b0;
    end else if (finish) begin
      keyArmed_ff <= !lastCmd_ff[15] &&
                     lastCmd_ff[14:8] == ADDR_RESET_KEY &&
                     lastCmd_ff[7:0] == KEY_FIRST;
      if (!lastCmd_ff[15] && lastCmd_ff[14:8] == ADDR_CONFIG) begin
        crcMode_ff <= lastCmd_ff[CFG_CRC_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdata_ff <= 16'h0000;
    end else if (regRd) begin
      case (regAddr)
        HOST_FRAME: regRdata_ff <= lastCmd_ff;
        HOST_STATUS: regRdata_ff <= {13'h0000, crcMode_ff,
                                     initCnt_ff != 12'h000,
                                     state_ff != HS_IDLE};
        HOST_RESPONSE: regRdata_ff <= (frameLen_ff == CRC_FRAME_BITS) ?
                                      rxShift_ff[23:8] : rxShift_ff[15:0];
        HOST_RX_CRC: regRdata_ff <= {8'h00, rxShift_ff[7:0]};
        default: regRdata_ff <= 16'h0000;
      endcase
    end else begin
      regRdata_ff <= 16'h0000;
    end
  end

  assign link.sclk = sclk_ff;
  assign link.csB = csB_ff;
  assign link.sdi = sdi_ff;
  assign regRdata = regRdata_ff;
endmodule : switch_host

/* File: sim/spi_switch_checker.sv */
// Purpose: timing and value checks on the host-device link
// Assumes: sclk is made by the host from sys_clk
// Notes: rise count restarts at each select
`timescale 1ns/1ns
module spi_switch_checker
  import spi_switch_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // link
  input wire logic sclk,
  input wire logic csB,
  input wire logic sdi,
  input wire logic sdo,
  // device user side
  input wire logic [7:0] switchClose,
  input wire logic [7:0] errorFlags,
  input wire logic initBusy
);
  logic [7:0] rises_ff;
  logic [11:0] busy_ff;
  logic [3:0] idle_ff;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) rises_ff <= 8'h00;
    else if ($fell(csB)) rises_ff <= 8'h00;
    else if ($rose(sclk) && !csB) rises_ff <= rises_ff + 8'h01;
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) busy_ff <= 12'h000;
    else if (!initBusy) busy_ff <= 12'h000;
    else if (busy_ff != 12'hfff) busy_ff <= busy_ff + 12'h001;
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) idle_ff <= 4'h0;
    else if (!csB) idle_ff <= 4'h0;
    else if (idle_ff != 4'hf) idle_ff <= idle_ff + 4'h1;
  end
  property p_flag_zero;
    errorFlags[7:3] == 5'h00;
  endproperty
  a_flag_zero: assert property (p_flag_zero)
    else $error("upper flag bits set");
  property p_init_len;
    $fell(initBusy) |-> busy_ff >= INIT_COUNT - 12'd1 &&
      busy_ff <= INIT_COUNT + 12'd1;
  endproperty
  a_init_len: assert property (p_init_len)
    else $error("init phase length wrong");
  property p_quiet;
    $fell(csB) |-> !initBusy;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("select during init phase");
  property p_align;
    $rose(sclk) && !csB && rises_ff < 8'd8 |->
      sdo == ALIGN_BYTE[3'd7 - rises_ff[2:0]];
  endproperty
  a_align: assert property (p_align)
    else $error("alignment bit wrong");
  property p_write_edge;
    $changed(switchClose) |-> rises_ff >= 8'd16 && rises_ff[2:0] == 3'h0;
  endproperty
  a_write_edge: assert property (p_write_edge)
    else $error("switch update off frame end");
  property p_flag_time;
    $changed(errorFlags) |-> idle_ff < 4'd8;
  endproperty
  a_flag_time: assert property (p_flag_time)
    else $error("flags changed outside a frame");
  property p_init_dflt;
    initBusy && $past(initBusy) |->
      switchClose == SWITCH_RESET && errorFlags == FLAGS_RESET;
  endproperty
  a_init_dflt: assert property (p_init_dflt)
    else $error("outputs not default in init");
  property p_frame_len;
    $rose(csB) |-> rises_ff == 8'd16 || rises_ff == 8'd24;
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("host frame length wrong");
endmodule : spi_switch_checker

/* File: sim/tb_spi_switch_register_bank.sv */
// Purpose: host and device joined, second device bit-banged
// Assumes: bench link clock of 400 ns on the second device
// Notes: expected values are computed here
`timescale 1ns/1ns
module tb_spi_switch_register_bank
  import spi_switch_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst_b;
  logic [1:0] regAddr;
  logic [15:0] regWdata;
  logic regWr;
  logic regRd;
  logic [15:0] regRdata;
  logic [7:0] switchClose;
  logic [7:0] errorFlags;
  logic initBusy;
  logic [7:0] switchCloseB;
  logic [7:0] errorFlagsB;
  logic initBusyB;
  int n_fail = 0;
  int total_checks = 0;
  spi_switch_if link();
  spi_switch_if linkB();
  always #25 sys_clk = ~sys_clk;
  switch_host i_switch_host (.sys_clk(sys_clk), .rst_b(rst_b), .link(link),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata));
  switch_device i_switch_device (.sys_clk(sys_clk), .rst_b(rst_b),
    .link(link), .switchClose(switchClose), .errorFlags(errorFlags),
    .initBusy(initBusy));
  switch_device i_switch_device_b (.sys_clk(sys_clk), .rst_b(rst_b),
    .link(linkB), .switchClose(switchCloseB), .errorFlags(errorFlagsB),
    .initBusy(initBusyB));
  spi_switch_checker i_spi_switch_checker (.sys_clk(sys_clk),
    .rst_b(rst_b), .sclk(link.sclk), .csB(link.csB), .sdi(link.sdi),
    .sdo(link.sdo), .switchClose(switchClose), .errorFlags(errorFlags),
    .initBusy(initBusy));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask : chk
  function automatic logic [7:0] crc_ref(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction : crc_ref
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask : rd
  task automatic idle;
    logic [15:0] s;
    for (int i = 0; i < 4000; i++) begin
      rd(HOST_STATUS, s);
      if (s[1:0] === 2'b00) return;
    end
    $display("[FAIL] idle expected 0 seen %h", s[1:0]);
    n_fail++;
    end_of_test;
  endtask : idle
  task automatic cmd(input logic [15:0] w);
    idle;
    wr(HOST_FRAME, w);
    idle;
  endtask : cmd
  task automatic rdr(input logic [6:0] a, output logic [7:0] d);
    logic [15:0] r;
    cmd({1'b1, a, 8'h00});
    rd(HOST_RESPONSE, r);
    chk("align", ALIGN_BYTE, r[15:8]);
    d = r[7:0];
  endtask : rdr
  // bench-made frame on the second link, skewed off the system clock
  task automatic bb(input logic [47:0] w, input int n);
    #37;
    linkB.csB = 1'b0;
    for (int i = 0; i < n; i++) begin
      linkB.sdi = w[47 - i];
      #200 linkB.sclk = 1'b1;
      #200 linkB.sclk = 1'b0;
    end
    #200 linkB.csB = 1'b1;
    linkB.sdi = ~linkB.sdi;
    #400;
  endtask : bb
  task automatic t_init;
    bb({1'b0, ADDR_SWITCH, 8'hff, 32'h0}, 16);
    chk("early write", 8'h00, switchCloseB);
    chk("busy", 8'h01, {7'h0, initBusyB});
    for (int i = 0; i < 3000 && initBusyB !== 1'b0; i++) @(posedge sys_clk);
    chk("busy end", 8'h00, {7'h0, initBusyB});
    if (initBusyB !== 1'b0) end_of_test;
  endtask : t_init
  task automatic t_defaults;
    logic [7:0] d;
    logic [15:0] s;
    logic [6:0] ad [4] = '{ADDR_SWITCH, ADDR_CONFIG, ADDR_FLAGS, ADDR_BURST};
    logic [7:0] ex [4] = '{SWITCH_RESET, CONFIG_RESET, FLAGS_RESET,
      BURST_RESET};
    for (int i = 0; i < 4; i++) begin
      rdr(ad[i], d);
      chk("reset value", ex[i], d);
    end
    wr(HOST_STATUS, 16'hffff);
    rd(HOST_STATUS, s);
    chk("status", 8'h00, s[7:0]);
    chk("no flag", 8'h00, errorFlags);
  endtask : t_defaults
  task automatic t_switch;
    logic [7:0] d;
    logic [7:0] v [2] = '{8'ha5, 8'h5a};
    for (int i = 0; i < 2; i++) begin
      cmd({1'b0, ADDR_SWITCH, v[i]});
      chk("switches", v[i], switchClose);
      rdr(ADDR_SWITCH, d);
      chk("switch read", v[i], d);
    end
  endtask : t_switch
  task automatic t_addr;
    logic [15:0] s;
    cmd({1'b0, ADDR_FLAGS, 8'hff});
    chk("ro write", 8'h04, errorFlags);
    cmd(CLEAR_FRAME);
    chk("clear", 8'h00, errorFlags);
    cmd({1'b1, 7'h04, 8'h00});
    chk("bad read", 8'h04, errorFlags);
    cmd(CLEAR_FRAME);
    cmd({1'b0, ADDR_CONFIG, 8'hfa});
    rd(HOST_FRAME, s);
    chk("masked", 8'h02, s[7:0]);
    cmd({1'b0, 7'h07, 8'h12});
    chk("detect off", 8'h00, errorFlags);
    cmd({1'b0, ADDR_CONFIG, CONFIG_RESET});
  endtask : t_addr
  task automatic t_crc;
    logic [7:0] d;
    logic [15:0] s;
    cmd({1'b0, ADDR_CONFIG, 8'h07});
    rd(HOST_STATUS, s);
    chk("crc mode", 8'h04, s[7:0]);
    cmd({1'b0, ADDR_SWITCH, 8'h3c});
    chk("crc write", 8'h3c, switchClose);
    rdr(ADDR_SWITCH, d);
    rd(HOST_RX_CRC, s);
    chk("tx crc", crc_ref({1'b1, ADDR_SWITCH, 8'h3c}), s[7:0]);
    cmd({1'b0, ADDR_FLAGS, 8'h00});
    cmd(CLEAR_FRAME);
    chk("crc clear", 8'h00, errorFlags);
    cmd({1'b0, ADDR_CONFIG, CONFIG_RESET});
  endtask : t_crc
  task automatic t_soft;
    logic [7:0] d;
    cmd({1'b0, ADDR_BURST, 8'h01});
    cmd({1'b0, ADDR_RESET_KEY, KEY_FIRST});
    cmd({1'b0, ADDR_SWITCH, 8'h78});
    cmd({1'b0, ADDR_RESET_KEY, KEY_SECOND});
    chk("disarmed", 8'h78, switchClose);
    cmd({1'b0, ADDR_RESET_KEY, KEY_FIRST});
    wr(HOST_FRAME, {1'b0, ADDR_RESET_KEY, KEY_SECOND});
    for (int i = 0; i < 1000 && initBusy !== 1'b1; i++) @(posedge sys_clk);
    chk("reinit", 8'h01, {7'h0, initBusy});
    if (initBusy !== 1'b1) end_of_test;
    idle;
    chk("sw reset", SWITCH_RESET, switchClose);
    rdr(ADDR_BURST, d);
    chk("burst reset", BURST_RESET, d);
  endtask : t_soft
  task automatic t_count;
    bb({1'b0, ADDR_SWITCH, 8'h99, 32'h0}, 15);
    chk("short", 8'h00, switchCloseB);
    chk("short flag", 8'h02, errorFlagsB);
    bb({CLEAR_FRAME, 32'h0}, 16);
    bb({1'b0, ADDR_SWITCH, 8'h99, 32'h0}, 17);
    chk("long", 8'h99, switchCloseB);
    chk("long flag", 8'h02, errorFlagsB);
    bb({CLEAR_FRAME, 32'h0}, 16);
  endtask : t_count
  task automatic t_burst;
    logic [47:0] two;
    two = {1'b0, ADDR_SWITCH, 8'h33, 1'b0, ADDR_SWITCH, 8'h44, 16'h0};
    bb({1'b0, ADDR_BURST, 8'h01, 32'h0}, 16);
    bb(two, 32);
    chk("burst", 8'h44, switchCloseB);
    chk("burst ok", 8'h00, errorFlagsB);
    bb(two, 24);
    chk("burst odd", 8'h02, errorFlagsB);
    bb({CLEAR_FRAME, 32'h0}, 16);
    bb({1'b0, ADDR_BURST, 8'h00, 32'h0}, 16);
    bb(two, 32);
    chk("no burst", 8'h33, switchCloseB);
    chk("no burst flag", 8'h02, errorFlagsB);
    bb({CLEAR_FRAME, 32'h0}, 16);
  endtask : t_burst
  task automatic t_crc_err;
    logic [15:0] f;
    f = {1'b0, ADDR_SWITCH, 8'hc3};
    bb({1'b0, ADDR_CONFIG, 8'h07, 32'h0}, 16);
    bb({f, crc_ref(f) ^ 8'h01, 24'h0}, 24);
    chk("bad crc", 8'h33, switchCloseB);
    chk("crc flag", 8'h01, errorFlagsB);
    bb({CLEAR_FRAME, crc_ref(CLEAR_FRAME) ^ 8'h80, 24'h0}, 24);
    chk("bad clear", 8'h01, errorFlagsB);
    bb({CLEAR_FRAME, crc_ref(CLEAR_FRAME), 24'h0}, 24);
    chk("good clear", 8'h00, errorFlagsB);
    bb({f, 32'h0}, 16);
    chk("16 in crc", 8'h02, errorFlagsB);
    bb({f, crc_ref(f), 24'h0}, 24);
    chk("good crc", 8'hc3, switchCloseB);
  endtask : t_crc_err
  initial begin
    rst_b = 1'b0;
    regAddr = 2'h0;
    regWdata = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
    linkB.sclk = 1'b0;
    linkB.csB = 1'b1;
    linkB.sdi = 1'b0;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_init;
    t_defaults;
    t_switch;
    t_addr;
    t_crc;
    t_soft;
    t_count;
    t_burst;
    t_crc_err;
    end_of_test;
  end
endmodule : tb_spi_switch_register_bank
